// file: src/ocb_pkg.sv
// constants for the overcurrent status bank of half-bridges five to twelve
// Summary of operation
// - register code 011 10 in the command frame selects the bridges five to eight flags
// - register code 111 10 in the command frame selects the bridges nine to twelve flags
// - bridges five to eight: bridge pairs, high side above low, bridge eight at top
// - bridges nine to twelve: bridge pairs, high side above low, bridge twelve at top
// - a detected overcurrent sets that switch's flag, which stays until cleared
// - a set flag keeps only its own switch off
// - every flag is zero after reset until an overcurrent arrives
// - global load error is the OR of all overcurrent and open-load flags
package ocb_pkg;
   localparam int OCB_REG_W = 8;
   localparam int OCB_CODE_W = 5;
   localparam int OCB_SW_N = 2 * OCB_REG_W;
   localparam int OCB_OTHER_W = 32;
   localparam logic [OCB_CODE_W-1:0] OCB_CODE_B5_8 = 5'h0e;
   localparam logic [OCB_CODE_W-1:0] OCB_CODE_B9_12 = 5'h1e;
   localparam logic [OCB_REG_W-1:0] OCB_FLAGS_RST = 8'h00;
   localparam logic [OCB_REG_W-1:0] OCB_RD_UNMAPPED = 8'h00;
   // switch index inside one register: bridge slot times two, plus one for high side
   localparam int OCB_HIGH_OFS = 1;
   localparam int OCB_LOW_OFS = 0;
endpackage

// file: src/ocb_bank.sv
// overcurrent flag registers for bridges five to twelve with per-switch shutdown
`timescale 1ns/1ns
module ocb_bank (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // overcurrent comparator levels, asynchronous; [7:0] bridges 5-8, [15:8] bridges 9-12
   input wire logic [ocb_pkg::OCB_SW_N-1:0] oc_detect_i,
   // decoded command frame from the serial front end
   input wire logic cmd_valid_i,
   input wire logic [ocb_pkg::OCB_CODE_W-1:0] cmd_code_i,
   input wire logic cmd_clear_i,
   output logic rd_valid_o,
   output logic rd_hit_o,
   output logic [ocb_pkg::OCB_REG_W-1:0] rd_data_o,
   // switch gating
   input wire logic [ocb_pkg::OCB_SW_N-1:0] switch_cmd_i,
   output logic [ocb_pkg::OCB_SW_N-1:0] switch_en_o,
   // global load error
   input wire logic [ocb_pkg::OCB_OTHER_W-1:0] other_err_i,
   output logic global_load_error_o,
   // raw flag view
   output logic [ocb_pkg::OCB_REG_W-1:0] overcurrent_flags_bridges_5_to_8_o,
   output logic [ocb_pkg::OCB_REG_W-1:0] overcurrent_flags_bridges_9_to_12_o
);
   import ocb_pkg::*;

   // code match shared by both registers
   function automatic logic code_is(input logic [OCB_CODE_W-1:0] code, input logic [OCB_CODE_W-1:0] ref_code);
      code_is = (code == ref_code);
   endfunction

   logic [OCB_SW_N-1:0] det_meta_q;
   logic [OCB_SW_N-1:0] det_sync_q;
   logic [OCB_REG_W-1:0] overcurrent_flags_bridges_5_to_8_q;
   logic [OCB_REG_W-1:0] overcurrent_flags_bridges_9_to_12_q;
   logic [OCB_REG_W-1:0] flags_lo_d;
   logic [OCB_REG_W-1:0] flags_hi_d;
   logic [OCB_REG_W-1:0] rd_data_q;
   logic [OCB_REG_W-1:0] rd_data_d;
   logic rd_valid_q;
   logic rd_hit_q;
   logic [OCB_SW_N-1:0] switch_en_q;
   logic global_err_q;
   wire sel_lo;
   wire sel_hi;
   wire clr_lo;
   wire clr_hi;
   wire [OCB_REG_W-1:0] set_lo;
   wire [OCB_REG_W-1:0] set_hi;
   wire [OCB_SW_N-1:0] all_flags;

   // two-stage synchroniser for the comparator levels
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         det_meta_q <= '0;
         det_sync_q <= '0;
      end else begin
         det_meta_q <= oc_detect_i;
         det_sync_q <= det_meta_q;
      end
   end

   // register selection from the frame's code
   assign sel_lo = cmd_valid_i && code_is(cmd_code_i, OCB_CODE_B5_8);
   assign sel_hi = cmd_valid_i && code_is(cmd_code_i, OCB_CODE_B9_12);
   assign clr_lo = sel_lo && cmd_clear_i;
   assign clr_hi = sel_hi && cmd_clear_i;

   // bit k of each register is switch k: 2*(bridge-first)+1 high, +0 low
   assign set_lo = det_sync_q[OCB_REG_W-1:0];
   assign set_hi = det_sync_q[OCB_SW_N-1:OCB_REG_W];

   // sticky flags; a new event wins over a clear in the same cycle
   assign flags_lo_d = (clr_lo ? OCB_FLAGS_RST : overcurrent_flags_bridges_5_to_8_q) | set_lo;
   assign flags_hi_d = (clr_hi ? OCB_FLAGS_RST : overcurrent_flags_bridges_9_to_12_q) | set_hi;

   // read data: contents before the clear, zero for other codes
   assign rd_data_d = sel_lo ? overcurrent_flags_bridges_5_to_8_q :
                      sel_hi ? overcurrent_flags_bridges_9_to_12_q : OCB_RD_UNMAPPED;

   assign all_flags = {overcurrent_flags_bridges_9_to_12_q, overcurrent_flags_bridges_5_to_8_q};

   // flag storage
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         overcurrent_flags_bridges_5_to_8_q <= OCB_FLAGS_RST;
         overcurrent_flags_bridges_9_to_12_q <= OCB_FLAGS_RST;
      end else begin
         overcurrent_flags_bridges_5_to_8_q <= flags_lo_d;
         overcurrent_flags_bridges_9_to_12_q <= flags_hi_d;
      end
   end

   // read answer, one cycle after the command
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_valid_q <= 1'b0;
         rd_hit_q <= 1'b0;
         rd_data_q <= OCB_RD_UNMAPPED;
      end else begin
         rd_valid_q <= cmd_valid_i;
         rd_hit_q <= sel_lo || sel_hi;
         if (cmd_valid_i) begin
            rd_data_q <= rd_data_d;
         end
      end
   end

   // switch gating and global error, registered from the stored flags
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         switch_en_q <= '0;
         global_err_q <= 1'b0;
      end else begin
         switch_en_q <= switch_cmd_i & ~all_flags;
         global_err_q <= (|all_flags) || (|other_err_i);
      end
   end

   assign rd_valid_o = rd_valid_q;
   assign rd_hit_o = rd_hit_q;
   assign rd_data_o = rd_data_q;
   assign switch_en_o = switch_en_q;
   assign global_load_error_o = global_err_q;
   assign overcurrent_flags_bridges_5_to_8_o = overcurrent_flags_bridges_5_to_8_q;
   assign overcurrent_flags_bridges_9_to_12_o = overcurrent_flags_bridges_9_to_12_q;
endmodule

// file: tb/ocb_bank_props.sv
// checker for the overcurrent status bank
`timescale 1ns/1ns
module ocb_bank_props import ocb_pkg::*; (input logic ref_clk_i, rst_n_i, cmd_valid_i, cmd_clear_i, rd_valid_o,
   rd_hit_o, global_load_error_o, input logic [4:0] cmd_code_i, input logic [7:0] rd_data_o,
   overcurrent_flags_bridges_5_to_8_o, overcurrent_flags_bridges_9_to_12_o, input logic [15:0] oc_detect_i,
   switch_cmd_i, switch_en_o, input logic [31:0] other_err_i);
   // all sixteen flags and the two register decodes
   wire [15:0] f = {overcurrent_flags_bridges_9_to_12_o, overcurrent_flags_bridges_5_to_8_o};
   wire lo = cmd_valid_i && cmd_code_i == OCB_CODE_B5_8;
   wire hi = cmd_valid_i && cmd_code_i == OCB_CODE_B9_12;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_rd; cmd_valid_i ##1 rd_valid_o && rd_hit_o == $past(lo || hi); endsequence
   a_read_answer: assert property (cmd_valid_i |-> s_rd) else $error("rd");
   a_data_low: assert property (lo |=> rd_data_o == $past(f[7:0])) else $error("lo");
   a_data_high: assert property (hi |=> rd_data_o == $past(f[15:8])) else $error("hi");
   a_flag_set: assert property (##3 (f & $past(oc_detect_i, 3)) == $past(oc_detect_i, 3))
      else $error("set");
   a_flag_hold: assert property ($past(rst_n_i && !(cmd_valid_i && cmd_clear_i)) |-> (f & $past(f)) == $past(f))
      else $error("hold");
   a_gate_off: assert property ($past(rst_n_i) |-> switch_en_o == $past(switch_cmd_i & ~f))
      else $error("en");
   a_global_or: assert property ($past(rst_n_i) |-> global_load_error_o == $past(|{f, other_err_i}))
      else $error("le");
   a_reset_zero: assert property (!$past(rst_n_i) |-> f == 16'h0000) else $error("rst");
endmodule
bind ocb_bank ocb_bank_props i_props (.*);

// file: tb/ocb_host.sv
// serial host stand-in issuing decoded frames
`timescale 1ns/1ns
module ocb_host (input logic ref_clk_i, output logic cmd_valid_i = 1'b0, output logic [4:0] cmd_code_i = 5'h00,
   output logic cmd_clear_i = 1'b0);
   // one frame; released lines show the inverse of the last value
   task frame(input logic [4:0] c, input logic k);
      @(posedge ref_clk_i) {cmd_valid_i, cmd_code_i, cmd_clear_i} <= {1'b1, c, k};
      @(posedge ref_clk_i) {cmd_valid_i, cmd_code_i, cmd_clear_i} <= {1'b0, ~c, ~k};
   endtask
endmodule

// file: tb/test_overcurrent_status_bank_hb5_12.sv
// bench for the overcurrent status bank
`timescale 1ns/1ns
module test_overcurrent_status_bank_hb5_12;
   import ocb_pkg::*;
   logic ref_clk_i = 1'b0, rst_n_i = 1'b0, cmd_valid_i, cmd_clear_i, rd_valid_o, rd_hit_o, global_load_error_o;
   logic [4:0] cmd_code_i, uc;
   logic [7:0] rd_data_o;
   logic [15:0] oc_detect_i = 16'h0000, switch_cmd_i = 16'h0000, switch_en_o;
   logic [31:0] other_err_i = 32'h0000_0000;
   int bad_count = 0, tests_run = 0, m[3];
   always #5 ref_clk_i = ~ref_clk_i;
   ocb_host i_host (.*);
   ocb_bank i_dut (.*, .overcurrent_flags_bridges_5_to_8_o(), .overcurrent_flags_bridges_9_to_12_o());
   task chk(input logic [31:0] g, e);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   // one frame against the model image; entry 2 stands for unmapped
   task rd(input int r, input logic [4:0] c, input logic k);
      i_host.frame(c, k);
      #1 chk(32'({rd_valid_o, rd_hit_o, rd_data_o}), 32'({1'b1, r < 2, m[r][7:0]}));
      if (k) m[r] = 0;
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      void'($urandom(32'hf904));
      repeat (6) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      rd(0, OCB_CODE_B5_8, 1'b0);
      rd(1, OCB_CODE_B9_12, 1'b0);
      $display("reset done");
      for (int i = 0; i < 16; i++) begin
         @(posedge ref_clk_i) oc_detect_i <= 16'h0001 << i;
         switch_cmd_i <= 16'($urandom);
         m[i / 8] |= 1 << (i % 8);
         @(posedge ref_clk_i) oc_detect_i <= 16'h0000;
         repeat (4) @(posedge ref_clk_i);
         #1 chk(32'(switch_en_o), 32'(switch_cmd_i & ~(16'h0001 << i)));
         chk(32'(global_load_error_o), 32'h1);
         for (int k = 0; k < 3; k++) rd(i / 8, i < 8 ? OCB_CODE_B5_8 : OCB_CODE_B9_12, k == 1);
         @(posedge ref_clk_i) #1 chk(32'(switch_en_o), 32'(switch_cmd_i));
         chk(32'(global_load_error_o), 32'h0);
         $display("switch %0d done", i);
      end
      uc = 5'($urandom);
      if (uc inside {OCB_CODE_B5_8, OCB_CODE_B9_12}) uc ^= 5'h01;
      @(posedge ref_clk_i) other_err_i <= 32'h1 << ($urandom % 32);
      rd(2, uc, 1'b1);
      chk(32'(global_load_error_o), 32'h1);
      $display("unmapped done");
      // comparator held high across a clear: the flag sets again at once
      @(posedge ref_clk_i) oc_detect_i <= 16'h8000;
      repeat (4) @(posedge ref_clk_i);
      m[1] = 8'h80;
      rd(1, OCB_CODE_B9_12, 1'b1);
      m[1] = 8'h80;
      rd(1, OCB_CODE_B9_12, 1'b0);
      @(posedge ref_clk_i) oc_detect_i <= 16'h0000;
      repeat (4) @(posedge ref_clk_i);
      rd(1, OCB_CODE_B9_12, 1'b1);
      rd(1, OCB_CODE_B9_12, 1'b0);
      $display("held comparator done");
      // reset in mid-run with a flag set: all flags back to zero
      @(posedge ref_clk_i) oc_detect_i <= 16'h0004;
      @(posedge ref_clk_i) oc_detect_i <= 16'h0000;
      repeat (4) @(posedge ref_clk_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      m[0] = 0;
      m[1] = 0;
      rd(0, OCB_CODE_B5_8, 1'b0);
      rd(1, OCB_CODE_B9_12, 1'b0);
      $display("second reset done");
      close_out;
   end
endmodule
